// File: hw/seqex_handler.v
// Sequencer exception handler: take, redirect, save and return
//
// Contract
// - Taking an enabled regular exception sets pending bit 62, an emulation one sets bit 63.
// - Fetch is redirected to the software vector, or to the emulation instruction register.
// - The PC is saved to the exception return reg, or the debug return reg for emulation.
// - Taking an enabled exception flushes every instruction in the pipeline.
// - An exception arising while disabled is dropped and never latched.
// - Processing starts only when the causing instruction is in execute stage two, aborting all.
// - An aborted speculative instruction raises no exception.
// - A predicated-false instruction still raises its exception.
// - Taking an exception leaves the global hardware disable bit 60 unchanged.
// - Return from an exception routine does not clear the global hardware disable bit.
// - Hardware interrupts rank below software exceptions and cannot preempt them.
// - Return clears the highest pending bit, branches to the interrupt return reg, and clears bit 60 only when bits 62 and 63 are both clear.
`timescale 1ns/100ps
`default_nettype none
`include "seqex_consts.vh"
module seqex_handler (
   input  wire                          i_sys_clk,
   input  wire                          i_rst_n,
   input  wire                          i_ex2_valid,
   input  wire                          i_ex2_exc,
   input  wire                          i_ex2_emu,
   input  wire                          i_ex2_spec_aborted,
   input  wire                          i_ex2_pred_false,
   input  wire [`SEQEX_ADDR_W-1:0]      i_ex2_pc,
   input  wire                          i_exc_enable,
   input  wire                          i_emu_enable,
   input  wire                          i_hw_irq_req,
   input  wire [`SEQEX_ADDR_W-1:0]      i_hw_irq_vector,
   input  wire                          i_return_from_interrupt,
   input  wire [`SEQEX_ADDR_W-1:0]      i_sw_exception_vector,
   input  wire [`SEQEX_ADDR_W-1:0]      i_emulation_instr_reg,
   input  wire                          i_irr_wr,
   input  wire [`SEQEX_ADDR_W-1:0]      i_irr_wdata,
   input  wire                          i_alias_wr,
   input  wire                          i_alias_rd,
   output reg  [`SEQEX_PMASK_W-1:0]     o_pmask,
   output reg                           o_fetch_redirect,
   output reg  [`SEQEX_ADDR_W-1:0]      o_fetch_addr,
   output reg  [`SEQEX_ADDR_W-1:0]      o_exception_return_reg,
   output reg  [`SEQEX_ADDR_W-1:0]      o_debug_return_reg,
   output reg  [`SEQEX_ADDR_W-1:0]      o_interrupt_return_reg,
   output wire [`SEQEX_NUM_STAGES-1:0]  o_pipe_abort,
   output reg                           o_exc_dropped,
   output reg                           o_hw_irq_taken
);
   wire [`SEQEX_PMASK_W-1:0] clr_mask;
   wire                      pend_any;
   reg                       raise;
   reg                       take_reg;
   reg                       take_emu;
   reg                       take_any;
   reg                       drop;
   reg                       exc_active;
   reg                       take_hw;
   reg [`SEQEX_PMASK_W-1:0]  next_pmask;
   reg [`SEQEX_PMASK_W-1:0]  ret_clear;

   seqex_prio_enc u_prio (
      .i_mask       (o_pmask),
      .o_clear_mask (clr_mask),
      .o_any        (pend_any)
   );

   seqex_flush_ctl u_flush (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_trigger (take_any),
      .o_abort   (o_pipe_abort)
   );

   always @* begin
      // Predicate result is ignored on purpose; only a speculative abort cancels
      raise = i_ex2_valid & ~i_ex2_spec_aborted & (i_ex2_exc | i_ex2_emu);
      // Emulation outranks a regular exception in the same cycle
      take_emu = raise & i_ex2_emu & i_emu_enable;
      take_reg = raise & ~take_emu & i_ex2_exc & i_exc_enable;
      take_any = take_emu | take_reg;
      drop = raise & ~take_any;
      exc_active = o_pmask[`SEQEX_BIT_REG_EXC] | o_pmask[`SEQEX_BIT_EMU_EXC];
      // Exceptions win over hardware requests, and block them while being served
      take_hw = i_hw_irq_req & ~take_any & ~exc_active & ~o_pmask[`SEQEX_BIT_GLOBAL_HW];
      // Return clears the top pending bit; bit 60 is cleared only for a hardware return
      ret_clear = clr_mask;
      if (exc_active) begin
         ret_clear[`SEQEX_BIT_GLOBAL_HW] = 1'b0;
      end else if (pend_any) begin
         ret_clear[`SEQEX_BIT_GLOBAL_HW] = 1'b1;
      end
      next_pmask = o_pmask;
      if (i_return_from_interrupt) begin
         next_pmask = next_pmask & ~ret_clear;
      end
      if (i_alias_wr) begin
         next_pmask[`SEQEX_BIT_GLOBAL_HW] = 1'b1;
      end
      if (i_alias_rd) begin
         next_pmask[`SEQEX_BIT_GLOBAL_HW] = 1'b0;
      end
      if (take_hw) begin
         next_pmask[`SEQEX_BIT_GLOBAL_HW] = 1'b1;
      end
      // Taking sets wins over a return clearing in the same cycle
      if (take_reg) begin
         next_pmask[`SEQEX_BIT_REG_EXC] = 1'b1;
      end
      if (take_emu) begin
         next_pmask[`SEQEX_BIT_EMU_EXC] = 1'b1;
      end
   end

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pmask                <= `SEQEX_PMASK_RST;
         o_fetch_redirect       <= 1'b0;
         o_fetch_addr           <= `SEQEX_ADDR_RST;
         o_exception_return_reg <= `SEQEX_ADDR_RST;
         o_debug_return_reg     <= `SEQEX_ADDR_RST;
         o_interrupt_return_reg <= `SEQEX_ADDR_RST;
         o_exc_dropped          <= 1'b0;
         o_hw_irq_taken         <= 1'b0;
      end else begin
         o_pmask          <= next_pmask;
         o_exc_dropped    <= drop;
         o_hw_irq_taken   <= take_hw;
         o_fetch_redirect <= take_any | take_hw | i_return_from_interrupt;
         if (take_emu) begin
            o_fetch_addr       <= i_emulation_instr_reg;
            o_debug_return_reg <= i_ex2_pc;
         end else if (take_reg) begin
            o_fetch_addr           <= i_sw_exception_vector;
            o_exception_return_reg <= i_ex2_pc;
         end else if (take_hw) begin
            o_fetch_addr <= i_hw_irq_vector;
         end else if (i_return_from_interrupt) begin
            o_fetch_addr <= o_interrupt_return_reg;
         end
         // Hardware interrupt return kept apart so exceptions can nest inside it
         if (take_hw) begin
            o_interrupt_return_reg <= i_ex2_pc;
         end else if (i_irr_wr | i_alias_wr) begin
            o_interrupt_return_reg <= i_irr_wdata;
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/seqex_consts.vh
// Constants for the sequencer exception handler
`ifndef SEQEX_CONSTS_VH
`define SEQEX_CONSTS_VH
`define SEQEX_ADDR_W          32
`define SEQEX_PMASK_W         64
`define SEQEX_BIT_GLOBAL_HW   60
`define SEQEX_BIT_REG_EXC     62
`define SEQEX_BIT_EMU_EXC     63
`define SEQEX_PMASK_RST       64'h0000000000000000
`define SEQEX_ADDR_RST        32'h00000000
`define SEQEX_NUM_STAGES      3
`endif

// File: hw/seqex_prio_enc.v
// Finds the highest set bit of the pending mask
`timescale 1ns/100ps
`default_nettype none
`include "seqex_consts.vh"
module seqex_prio_enc (
   input  wire [`SEQEX_PMASK_W-1:0] i_mask,
   output reg  [`SEQEX_PMASK_W-1:0] o_clear_mask,
   output reg                       o_any
);
   integer idx;
   reg     found;
   always @* begin
      found = 1'b0;
      o_clear_mask = {`SEQEX_PMASK_W{1'b0}};
      for (idx = `SEQEX_PMASK_W - 1; idx >= 0; idx = idx - 1) begin
         if (!found && i_mask[idx]) begin
            o_clear_mask[idx] = 1'b1;
            found = 1'b1;
         end
      end
      o_any = found;
   end
endmodule
`default_nettype wire

// File: hw/seqex_flush_ctl.v
// Pipeline flush pulse generator
`timescale 1ns/100ps
`default_nettype none
`include "seqex_consts.vh"
module seqex_flush_ctl (
   input  wire                          i_sys_clk,
   input  wire                          i_rst_n,
   input  wire                          i_trigger,
   output reg  [`SEQEX_NUM_STAGES-1:0]  o_abort
);
   // All stages are killed at once; the redirect refills the pipe
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_abort <= {`SEQEX_NUM_STAGES{1'b0}};
      end else begin
         o_abort <= {`SEQEX_NUM_STAGES{i_trigger}};
      end
   end
endmodule
`default_nettype wire

// File: verification/seqex_handler_asserts.sv
// Port assertions for the sequencer exception handler
`timescale 1ns/100ps
`default_nettype none
module seqex_handler_asserts (
   input wire logic        i_sys_clk, i_rst_n, i_ex2_valid, i_ex2_exc, i_ex2_emu,
   input wire logic        i_ex2_spec_aborted, i_exc_enable, i_emu_enable, i_hw_irq_req,
   input wire logic        i_return_from_interrupt, i_alias_wr, i_alias_rd,
   input wire logic        o_fetch_redirect, o_exc_dropped, o_hw_irq_taken,
   input wire logic [2:0]  o_pipe_abort,
   input wire logic [31:0] i_ex2_pc, i_sw_exception_vector, i_emulation_instr_reg,
   input wire logic [31:0] o_fetch_addr, o_exception_return_reg, o_debug_return_reg,
   input wire logic [63:0] o_pmask
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire lv = i_ex2_valid && !i_ex2_spec_aborted;
   wire rt = lv && i_ex2_exc && !i_ex2_emu && i_exc_enable;
   wire et = lv && i_ex2_emu && i_emu_enable;
   // Alias accesses also move bit 60, so they are kept out of the checks on it
   wire nal = !i_alias_wr && !i_alias_rd;
   a_reg_take: assert property (rt |=> o_pmask[62] &&
      o_exception_return_reg == $past(i_ex2_pc) && o_fetch_addr == $past(i_sw_exception_vector))
      else $error("regular take wrong");
   a_emu_take: assert property (et |=> o_pmask[63] &&
      o_debug_return_reg == $past(i_ex2_pc) && o_fetch_addr == $past(i_emulation_instr_reg))
      else $error("emulation take wrong");
   a_take_flush: assert property ((rt || et) |=> o_pipe_abort == 3'b111 && o_fetch_redirect)
      else $error("no flush");
   a_bit60_kept: assert property ((rt || et) && nal && !i_return_from_interrupt |=>
      $stable(o_pmask[60])) else $error("bit 60 moved");
   a_drop_lost: assert property (lv && i_ex2_exc && !i_ex2_emu && !i_exc_enable &&
      !i_return_from_interrupt && !i_hw_irq_req |=> o_exc_dropped && !o_fetch_redirect
      && $stable(o_pmask[63:62])) else $error("drop wrong");
   a_spec_quiet: assert property (i_ex2_valid && i_ex2_spec_aborted &&
      !i_return_from_interrupt |=> $stable(o_pmask[63:62]) && !o_exc_dropped)
      else $error("spec raised");
   a_hw_below: assert property (i_hw_irq_req && |o_pmask[63:62] |=> !o_hw_irq_taken)
      else $error("irq preempted");
   a_ret_keep60: assert property (i_return_from_interrupt && |o_pmask[63:62] && nal |=>
      $stable(o_pmask[60])) else $error("return cleared 60");
   a_ret_clears: assert property (i_return_from_interrupt && o_pmask[63] && !et |=>
      !o_pmask[63] && o_fetch_redirect) else $error("return wrong");
   cover property (rt);
   cover property (et);
   cover property (i_return_from_interrupt && o_pmask[62]);
endmodule
bind seqex_handler seqex_handler_asserts u_chk (.*);
`default_nettype wire

// File: verification/seqex_handler_test.sv
// Self-checking bench for the sequencer exception handler
`timescale 1ns/100ps
`default_nettype none
module seqex_handler_test;
   logic        c = 0, r = 0, v = 0, x = 0, m = 0, s = 0, p = 0, xe = 0, me = 0;
   logic        h = 0, t = 0, w = 0, fr, dp, ht;
   logic [31:0] pc = 0, wd = 0, fa, er, dr, ir;
   logic [63:0] pm;
   logic [2:0]  ab;
   int          fail_count = 0, tests_run = 0;
   seqex_handler u_dut (.i_sys_clk(c), .i_rst_n(r), .i_ex2_valid(v), .i_ex2_exc(x),
      .i_ex2_emu(m), .i_ex2_spec_aborted(s), .i_ex2_pred_false(p), .i_ex2_pc(pc),
      .i_exc_enable(xe), .i_emu_enable(me), .i_hw_irq_req(h), .i_hw_irq_vector(32'h00000300),
      .i_return_from_interrupt(t), .i_sw_exception_vector(32'h00001000),
      .i_emulation_instr_reg(32'h00002000), .i_irr_wr(w), .i_irr_wdata(wd), .i_alias_wr(1'b0),
      .i_alias_rd(1'b0), .o_pmask(pm), .o_fetch_redirect(fr), .o_fetch_addr(fa),
      .o_exception_return_reg(er), .o_debug_return_reg(dr), .o_interrupt_return_reg(ir),
      .o_pipe_abort(ab), .o_exc_dropped(dp), .o_hw_irq_taken(ht));
   initial forever #12.5 c = ~c;
   task chk(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One request cycle: flags are irq, return, irr write, valid, exc, emu, spec, pred
   task op(input logic [7:0] f, input logic [31:0] a);
      @(posedge c);
      {h, t, w, v, x, m, s, p} <= f;
      pc <= a;
      wd <= a;
      @(posedge c);
      {h, t, w, v, x, m, s, p} <= 8'h00;
      #1;
   endtask
   task t_irq_exc;
      op(8'h80, 0);
      chk({ht, pm[63:60]}, 5'h11);
      op(8'h19, 32'h100);
      chk({pm[63:60], fr, ab}, 8'h5f);
      chk({fa, er}, {32'h1000, 32'h100});
      op(8'h80, 0);
      chk({ht, pm[63:60]}, 5'h05);
      op(8'h20, 32'h100);
      op(8'h40, 0);
      chk({pm[63:60], fr, fa, ir}, {5'h03, 32'h100, 32'h100});
      op(8'h40, 0);
      chk(pm[63:60], 0);
      $display("irq and exception test done");
   endtask
   task t_emu;
      op(8'h1c, 32'h200);
      chk({pm[63:60], ab}, 7'h47);
      chk({fa, dr, er}, {32'h2000, 32'h200, 32'h100});
      op(8'h20, 32'h200);
      chk(ir, 32'h200);
      op(8'h60, 32'h100);
      chk({fa, ir}, {32'h200, 32'h100});
      chk(pm[63:60], 0);
      $display("emulation test done");
   endtask
   task t_drop;
      @(posedge c);
      xe <= 0;
      op(8'h18, 32'h300);
      chk({dp, fr, pm[63:60]}, 6'h20);
      @(posedge c);
      xe <= 1;
      op(0, 0);
      chk({fr, pm[62]}, 0);
      op(8'h1a, 32'h300);
      chk({dp, fr, ab, pm[62]}, 0);
      $display("drop and speculative test done");
   endtask
   // The tests need well under 100 cycles; ten microseconds leaves ample slack
   initial begin
      #10us;
      fail_count++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge c);
      r <= 1;
      xe <= 1;
      me <= 1;
      t_irq_exc();
      t_emu();
      t_drop();
      test_done();
   end
endmodule
`default_nettype wire
